// ### hdl/stmrc_pkg.sv
// constants, types and state layout of the standard timer register control
package stmrc_pkg;
    // register offsets on the plain register port
    localparam logic [2:0] OFS_CTL_A  = 3'h0;
    localparam logic [2:0] OFS_CTL_B  = 3'h1;
    localparam logic [2:0] OFS_CNT_LO = 3'h2;
    localparam logic [2:0] OFS_CNT_HI = 3'h3;
    localparam logic [2:0] OFS_CMPA_L = 3'h4;
    localparam logic [2:0] OFS_CMPA_H = 3'h5;
    localparam logic [2:0] OFS_CMPP   = 3'h6;
    // reset values and masks
    localparam logic [7:0]  REG_RST    = 8'h00;
    localparam logic [7:0]  CTLA_MASK  = 8'hf8;
    localparam logic [15:0] CNT_ZERO   = 16'h0000;
    localparam logic [15:0] CNT_ONE    = 16'h0001;
    localparam logic [15:0] CNT_MAX    = 16'hffff;
    localparam logic [16:0] FULL_SPAN  = 17'h10000;
    localparam logic [7:0]  BYTE_ZERO  = 8'h00;
    // field positions in timer_control_a
    localparam int PAUSE_BIT = 7;
    localparam int CKSEL_HI  = 6;
    localparam int CKSEL_LO  = 4;
    localparam int ON_BIT    = 3;
    // field positions in timer_control_b
    localparam int MODE_HI   = 7;
    localparam int MODE_LO   = 6;
    localparam int OFUNC_HI  = 5;
    localparam int OFUNC_LO  = 4;
    localparam int INIT_BIT  = 3;
    localparam int INV_BIT   = 2;
    localparam int SWAP_BIT  = 1;
    localparam int CLRSRC_BIT = 0;
    // counter clock select codes
    localparam logic [2:0] CK_SYS4  = 3'h0;
    localparam logic [2:0] CK_SYS   = 3'h1;
    localparam logic [2:0] CK_H16   = 3'h2;
    localparam logic [2:0] CK_H64   = 3'h3;
    localparam logic [2:0] CK_TBC   = 3'h4;
    localparam logic [2:0] CK_H8    = 3'h5;
    localparam logic [2:0] CK_EXTR  = 3'h6;
    localparam logic [2:0] CK_EXTF  = 3'h7;
    // divider terminal counts
    localparam logic [1:0] DIV4_END  = 2'h3;
    localparam logic [2:0] DIV8_END  = 3'h7;
    localparam logic [3:0] DIV16_END = 4'hf;
    localparam logic [5:0] DIV64_END = 6'h3f;
    // output function codes
    localparam logic [1:0] OF_00 = 2'h0;
    localparam logic [1:0] OF_01 = 2'h1;
    localparam logic [1:0] OF_10 = 2'h2;
    localparam logic [1:0] OF_11 = 2'h3;

    typedef enum logic [1:0] {
        MODE_CMP = 2'b00,
        MODE_CAP = 2'b01,
        MODE_PWM = 2'b10,
        MODE_TC  = 2'b11
    } stmrc_mode_t;

    typedef struct packed {
        logic [7:0]  ctla;
        logic [7:0]  ctlb;
        logic [7:0]  cmpal;
        logic [7:0]  cmpah;
        logic [7:0]  cmpp;
        logic [7:0]  rdata;
        logic [15:0] cnt;
        logic [1:0]  div4;
        logic [5:0]  hdiv;
        logic [1:0]  ext_s;
        logic        ext_d;
        logic [1:0]  tp_s;
        logic        tp_d;
        logic        lvl;
        logic        sp_act;
        logic        pin;
        logic        oe;
        logic        af;
        logic        pf;
    } stmrc_state_t;
endpackage : stmrc_pkg

// ### hdl/stmrc_timer.sv
// standard timer: registers, clock select, counter, comparators and output pin
//
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - pause freezes counter, release resumes from value
// - clock select picks one of eight sources
// - on rise clears counter; off holds value
// - on rise restores initial pin level
// - control A bits 2..0 read zero
// - mode field picks four modes
// - compare A match: none, low, high, toggle
// - PWM codes: inactive, active, PWM, single pulse
// - capture edge: rise, fall, both, off
// - initial level bit: start level or polarity
// - invert bit flips pin, unused in counter and capture modes
// - swap bit exchanges period and duty registers
// - clear source: A match, else P/overflow
// - clear source ignored in PWM and capture
// - counter readable as two read-only bytes
// - compare A is two writable bytes, reset zero
// - compare P matches counter high byte
// - sixteen bit up-counter against both comparators
// - clearing match raises its flag; overflow raises P only in capture or with compare P zero, not clear source A
// - clear source A forbids compare P flag
module stmrc_timer
    import stmrc_pkg::*;
(
    // clock and reset
    input  wire logic       ref_clk_in,
    input  wire logic       srst_in,
    // register port
    input  wire logic [2:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       reg_wr_in,
    input  wire logic       reg_rd_in,
    output var  logic [7:0] reg_rdata_out,
    // internal clock enables
    input  wire logic       high_clk_en_in,
    input  wire logic       timebase_en_in,
    // pins
    input  wire logic       external_clock_input_in,
    input  wire logic       timer_pin_in,
    output var  logic       timer_output_pin_out,
    output var  logic       timer_output_pin_oe_out,
    // comparator events
    output var  logic       compare_a_flag_out,
    output var  logic       compare_p_flag_out
);
    stmrc_state_t s_r;
    stmrc_state_t s_nxt;
    stmrc_mode_t  mode;
    logic        ext_rise;
    logic        ext_fall;
    logic        src_en;
    logic        tick;
    logic        on_rise;
    logic [15:0] inc;
    logic [15:0] cmpa;
    logic [15:0] pword;
    logic        ovf;
    logic        hit_a;
    logic        hit_p;
    logic        clr;
    logic        af_ev;
    logic        pf_ev;
    logic        cap_ev;
    logic        tp_rise;
    logic        tp_fall;
    logic [16:0] duty;
    logic        pwm_act;
    logic        act;
    logic [1:0]  ofunc;

    always_comb begin
        s_nxt = s_r;
        mode  = stmrc_mode_t'(s_r.ctlb[MODE_HI:MODE_LO]);
        ofunc = s_r.ctlb[OFUNC_HI:OFUNC_LO];
        // two-stage synchronisers, edges from the second stage only
        s_nxt.ext_s = {s_r.ext_s[0], external_clock_input_in};
        s_nxt.ext_d = s_r.ext_s[1];
        ext_rise    = s_r.ext_s[1] & ~s_r.ext_d;
        ext_fall    = ~s_r.ext_s[1] & s_r.ext_d;
        s_nxt.tp_s  = {s_r.tp_s[0], timer_pin_in};
        s_nxt.tp_d  = s_r.tp_s[1];
        tp_rise     = s_r.tp_s[1] & ~s_r.tp_d;
        tp_fall     = ~s_r.tp_s[1] & s_r.tp_d;
        // dividers
        s_nxt.div4 = s_r.div4 + 2'h1;
        if (high_clk_en_in) begin
            s_nxt.hdiv = s_r.hdiv + 6'h01;
        end
        case (s_r.ctla[CKSEL_HI:CKSEL_LO])
            CK_SYS4: src_en = (s_r.div4 == DIV4_END);
            CK_SYS:  src_en = 1'b1;
            CK_H16:  src_en = high_clk_en_in & (s_r.hdiv[3:0] == DIV16_END);
            CK_H64:  src_en = high_clk_en_in & (s_r.hdiv == DIV64_END);
            CK_TBC:  src_en = timebase_en_in;
            CK_H8:   src_en = high_clk_en_in & (s_r.hdiv[2:0] == DIV8_END);
            CK_EXTR: src_en = ext_rise;
            CK_EXTF: src_en = ext_fall;
            default: src_en = 1'b0;
        endcase
        tick = src_en & s_r.ctla[ON_BIT] & ~s_r.ctla[PAUSE_BIT];
        // comparators
        inc   = s_r.cnt + CNT_ONE;
        cmpa  = {s_r.cmpah, s_r.cmpal};
        pword = {s_r.cmpp, BYTE_ZERO};
        ovf   = (s_r.cnt == CNT_MAX);
        hit_a = (inc == cmpa) && (cmpa != CNT_ZERO);
        hit_p = (s_r.cmpp != BYTE_ZERO) ? (inc == pword) : ovf;
        // clear source and flags per mode
        clr    = 1'b0;
        af_ev  = 1'b0;
        pf_ev  = 1'b0;
        cap_ev = 1'b0;
        case (mode)
            MODE_CMP, MODE_TC: begin
                clr   = s_r.ctlb[CLRSRC_BIT] ? (hit_a | ovf) : hit_p;
                af_ev = hit_a;
                pf_ev = ~s_r.ctlb[CLRSRC_BIT] & hit_p;
            end
            MODE_PWM: begin
                clr   = s_r.ctlb[SWAP_BIT] ? (hit_a | ovf) : hit_p;
                af_ev = hit_a;
                pf_ev = hit_p;
            end
            MODE_CAP: begin
                clr   = ovf;
                pf_ev = ovf;
                case (ofunc)
                    OF_00:   cap_ev = tp_rise;
                    OF_01:   cap_ev = tp_fall;
                    OF_10:   cap_ev = tp_rise | tp_fall;
                    default: cap_ev = 1'b0;
                endcase
                cap_ev = cap_ev & s_r.ctla[ON_BIT];
            end
            default: clr = 1'b0;
        endcase
        s_nxt.af = (tick & af_ev) | cap_ev;
        s_nxt.pf = tick & pf_ev;
        if (tick) begin
            s_nxt.cnt = clr ? CNT_ZERO : inc;
        end
        // capture stores the count into compare A
        if (cap_ev) begin
            s_nxt.cmpal = s_r.cnt[7:0];
            s_nxt.cmpah = s_r.cnt[15:8];
        end
        // compare match output level
        if (tick && hit_a && mode == MODE_CMP) begin
            case (ofunc)
                OF_01:   s_nxt.lvl = 1'b0;
                OF_10:   s_nxt.lvl = 1'b1;
                OF_11:   s_nxt.lvl = ~s_r.lvl;
                default: s_nxt.lvl = s_r.lvl;
            endcase
        end
        // single pulse ends on compare A match or switch-off
        if ((tick && hit_a) || !s_r.ctla[ON_BIT]) begin
            s_nxt.sp_act = 1'b0;
        end
        // register writes; the counter bytes ignore writes
        on_rise = reg_wr_in && (reg_addr_in == OFS_CTL_A) &&
                  reg_wdata_in[ON_BIT] && !s_r.ctla[ON_BIT];
        if (reg_wr_in) begin
            case (reg_addr_in)
                OFS_CTL_A:  s_nxt.ctla  = reg_wdata_in & CTLA_MASK;
                OFS_CTL_B:  s_nxt.ctlb  = reg_wdata_in;
                OFS_CMPA_L: s_nxt.cmpal = reg_wdata_in;
                OFS_CMPA_H: s_nxt.cmpah = reg_wdata_in;
                OFS_CMPP:   s_nxt.cmpp  = reg_wdata_in;
                default:    s_nxt.ctla  = s_r.ctla;
            endcase
        end
        if (on_rise) begin
            s_nxt.cnt    = CNT_ZERO;
            s_nxt.lvl    = s_r.ctlb[INIT_BIT];
            s_nxt.sp_act = 1'b1;
        end
        // read data stands only in the cycle after the strobe
        s_nxt.rdata = BYTE_ZERO;
        if (reg_rd_in) begin
            case (reg_addr_in)
                OFS_CTL_A:  s_nxt.rdata = s_r.ctla & CTLA_MASK;
                OFS_CTL_B:  s_nxt.rdata = s_r.ctlb;
                OFS_CNT_LO: s_nxt.rdata = s_r.cnt[7:0];
                OFS_CNT_HI: s_nxt.rdata = s_r.cnt[15:8];
                OFS_CMPA_L: s_nxt.rdata = s_r.cmpal;
                OFS_CMPA_H: s_nxt.rdata = s_r.cmpah;
                OFS_CMPP:   s_nxt.rdata = s_r.cmpp;
                default:    s_nxt.rdata = BYTE_ZERO;
            endcase
        end
        // pwm duty compare; a duty at or above the period gives 100 percent
        if (s_r.ctlb[SWAP_BIT]) begin
            duty = (s_r.cmpp == BYTE_ZERO) ? FULL_SPAN : {1'b0, pword};
        end else begin
            duty = {1'b0, cmpa};
        end
        pwm_act = ({1'b0, s_r.cnt} < duty) & s_r.ctla[ON_BIT];
        case (ofunc)
            OF_00:   act = 1'b0;
            OF_01:   act = 1'b1;
            OF_10:   act = pwm_act;
            default: act = s_r.sp_act;
        endcase
        // pin drive
        case (mode)
            MODE_CMP: begin
                s_nxt.oe  = 1'b1;
                s_nxt.pin = s_r.lvl ^ s_r.ctlb[INV_BIT];
            end
            MODE_PWM: begin
                s_nxt.oe  = 1'b1;
                s_nxt.pin = (act ? s_r.ctlb[INIT_BIT] : ~s_r.ctlb[INIT_BIT]) ^ s_r.ctlb[INV_BIT];
            end
            default: begin
                s_nxt.oe  = 1'b0;
                s_nxt.pin = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign reg_rdata_out          = s_r.rdata;
    assign timer_output_pin_out    = s_r.pin;
    assign timer_output_pin_oe_out = s_r.oe;
    assign compare_a_flag_out      = s_r.af;
    assign compare_p_flag_out      = s_r.pf;

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (srst_in);

    AST_RSVD_ZERO: assert property (
        reg_rd_in && reg_addr_in == OFS_CTL_A |=> reg_rdata_out[2:0] == 3'h0)
        else $error("reserved control bits read nonzero");
    AST_PAUSE_HOLD: assert property (
        s_r.ctla[PAUSE_BIT] && !reg_wr_in |=> $stable(s_r.cnt))
        else $error("counter moved while paused");
    AST_ON_CLEAR: assert property (
        on_rise |=> s_r.cnt == CNT_ZERO)
        else $error("counter not cleared on switch-on");
    AST_OFF_HOLD: assert property (
        !s_r.ctla[ON_BIT] && !reg_wr_in |=> $stable(s_r.cnt))
        else $error("counter moved while off");
    AST_INIT_LVL: assert property (
        on_rise && mode == MODE_CMP |=> s_r.lvl == $past(s_r.ctlb[INIT_BIT]))
        else $error("initial level not restored");
    AST_PWM_FORCE: assert property (
        mode == MODE_PWM && ofunc == OF_01 |=>
        timer_output_pin_out == ($past(s_r.ctlb[INIT_BIT]) ^ $past(s_r.ctlb[INV_BIT])))
        else $error("forced active level wrong");
    AST_NO_PFLAG: assert property (
        s_r.ctlb[CLRSRC_BIT] && (mode == MODE_CMP || mode == MODE_TC) |=> !compare_p_flag_out)
        else $error("compare P flag with clear source A");
    AST_CMPA_WR: assert property (
        reg_wr_in && reg_addr_in == OFS_CMPA_L |=> s_r.cmpal == $past(reg_wdata_in))
        else $error("compare A low byte not written");
    AST_TC_NO_OE: assert property (
        mode == MODE_TC |=> !timer_output_pin_oe_out)
        else $error("pin driven in counter mode");
    AST_P_CLEAR: assert property (
        tick && !on_rise && mode == MODE_CMP && !s_r.ctlb[CLRSRC_BIT] && hit_p |=>
        s_r.cnt == CNT_ZERO && compare_p_flag_out)
        else $error("compare P match did not clear");

    // register port
    AST_RSVD_MASK: assert property (
        (s_r.ctla & ~CTLA_MASK) == BYTE_ZERO)
        else $error("reserved control bits stored");
    AST_CNT_RO: assert property (
        reg_wr_in && (reg_addr_in == OFS_CNT_LO || reg_addr_in == OFS_CNT_HI) && !tick |=> $stable(s_r.cnt))
        else $error("counter loaded by a write");
    AST_CMPAH_WR: assert property (
        reg_wr_in && reg_addr_in == OFS_CMPA_H |=> s_r.cmpah == $past(reg_wdata_in))
        else $error("compare A high byte not written");
    AST_CMPP_WR: assert property (
        reg_wr_in && reg_addr_in == OFS_CMPP |=> s_r.cmpp == $past(reg_wdata_in))
        else $error("compare P not written");
    AST_CTLB_WR: assert property (
        reg_wr_in && reg_addr_in == OFS_CTL_B |=> s_r.ctlb == $past(reg_wdata_in))
        else $error("control B not written");
    AST_RD_CNT_LO: assert property (
        reg_rd_in && reg_addr_in == OFS_CNT_LO |=> reg_rdata_out == $past(s_r.cnt[7:0]))
        else $error("counter low byte read wrong");
    AST_RD_CNT_HI: assert property (
        reg_rd_in && reg_addr_in == OFS_CNT_HI |=> reg_rdata_out == $past(s_r.cnt[15:8]))
        else $error("counter high byte read wrong");
    AST_RD_IDLE: assert property (
        !reg_rd_in |=> reg_rdata_out == BYTE_ZERO)
        else $error("read data outside read cycle");

    // counter and clearing
    AST_TICK_INC: assert property (
        tick && !clr && !on_rise |=> s_r.cnt == $past(inc))
        else $error("counter did not advance");
    AST_A_CLEAR: assert property (
        tick && !on_rise && mode == MODE_CMP && s_r.ctlb[CLRSRC_BIT] && hit_a |=>
        s_r.cnt == CNT_ZERO && compare_a_flag_out)
        else $error("compare A match did not clear");
    AST_PF_OVF: assert property (
        tick && !on_rise && mode == MODE_TC && !s_r.ctlb[CLRSRC_BIT] && s_r.cmpp == BYTE_ZERO && ovf |=>
        s_r.cnt == CNT_ZERO && compare_p_flag_out)
        else $error("overflow did not clear");
    AST_AZERO_NOFLAG: assert property (
        (mode == MODE_CMP || mode == MODE_TC) && cmpa == CNT_ZERO |=> !compare_a_flag_out)
        else $error("compare A flag with zero compare");

    // compare match output
    AST_LVL_LOW: assert property (
        tick && hit_a && mode == MODE_CMP && ofunc == OF_01 && !on_rise |=> !s_r.lvl)
        else $error("match did not drive low");
    AST_LVL_HIGH: assert property (
        tick && hit_a && mode == MODE_CMP && ofunc == OF_10 && !on_rise |=> s_r.lvl)
        else $error("match did not drive high");
    AST_LVL_TOGGLE: assert property (
        tick && hit_a && mode == MODE_CMP && ofunc == OF_11 && !on_rise |=> s_r.lvl == !$past(s_r.lvl))
        else $error("match did not toggle");
    AST_CMP_PIN: assert property (
        mode == MODE_CMP |=> timer_output_pin_out == ($past(s_r.lvl) ^ $past(s_r.ctlb[INV_BIT])))
        else $error("compare pin level wrong");

    // pwm and single pulse
    AST_PWM_INACT: assert property (
        mode == MODE_PWM && ofunc == OF_00 |=>
        timer_output_pin_out == (!$past(s_r.ctlb[INIT_BIT]) ^ $past(s_r.ctlb[INV_BIT])))
        else $error("forced inactive level wrong");
    AST_PWM_OE: assert property (
        mode == MODE_PWM |=> timer_output_pin_oe_out)
        else $error("pin not driven in pwm mode");
    AST_SP_START: assert property (
        on_rise |=> s_r.sp_act)
        else $error("single pulse not started");
    AST_SP_END: assert property (
        tick && hit_a && !on_rise |=> !s_r.sp_act)
        else $error("single pulse not ended");
    AST_SWAP_CLR: assert property (
        tick && !on_rise && mode == MODE_PWM && s_r.ctlb[SWAP_BIT] && hit_a |=> s_r.cnt == CNT_ZERO)
        else $error("swapped period not from compare A");
    AST_NOSWAP_CLR: assert property (
        tick && !on_rise && mode == MODE_PWM && !s_r.ctlb[SWAP_BIT] && hit_p |=> s_r.cnt == CNT_ZERO)
        else $error("period not from compare P");

    // capture
    AST_CAP_STORE: assert property (
        cap_ev && !(reg_wr_in && reg_addr_in == OFS_CMPA_L) |=> s_r.cmpal == $past(s_r.cnt[7:0]))
        else $error("capture did not store count");
    AST_CAP_OFF: assert property (
        mode == MODE_CAP && ofunc == OF_11 |=> !compare_a_flag_out)
        else $error("capture while disabled");
    AST_CAP_OVF: assert property (
        tick && !on_rise && mode == MODE_CAP && ovf |=> s_r.cnt == CNT_ZERO && compare_p_flag_out)
        else $error("capture mode overflow wrong");
    AST_OFF_NOCAP: assert property (
        mode == MODE_CAP && !s_r.ctla[ON_BIT] |=> !compare_a_flag_out)
        else $error("capture while switched off");

    COV_PWM: cover property (mode == MODE_PWM && ofunc == OF_10 && tick ##1 $changed(timer_output_pin_out));
    COV_PFLAG: cover property (compare_p_flag_out);
    COV_AFLAG_CMP: cover property (mode == MODE_CMP && compare_a_flag_out);
    COV_CAPTURE: cover property (cap_ev);
    COV_SPULSE: cover property (mode == MODE_PWM && ofunc == OF_11 && tick && hit_a);
endmodule : stmrc_timer

`default_nettype wire

// ### testbench/stmrc_timer_tb.sv
// self-checking bench for the standard timer register control
`timescale 1ns/1ps
`default_nettype none
module stmrc_timer_tb
    import stmrc_pkg::*;
;
    logic       ref_clk_in = 1'b0;
    logic       srst_in    = 1'b1;
    logic [2:0] addr       = 3'h0;
    logic [7:0] wdata      = 8'h00;
    logic       wr_s       = 1'b0;
    logic       rd_s       = 1'b0;
    logic       high_en    = 1'b0;
    logic       tbase_en   = 1'b0;
    logic       ext_clk    = 1'b0;
    logic       pin_level  = 1'b0;
    logic [7:0] rdata;
    logic       pin;
    logic       oe;
    logic       af;
    logic       pf;
    int         fails       = 0;
    int         comparisons = 0;
    int         cycles      = 0;
    int         n;
    bit         pseen;

    stmrc_timer stmrc_timer_i (
        .ref_clk_in              (ref_clk_in),
        .srst_in                 (srst_in),
        .reg_addr_in             (addr),
        .reg_wdata_in            (wdata),
        .reg_wr_in               (wr_s),
        .reg_rd_in               (rd_s),
        .reg_rdata_out           (rdata),
        .high_clk_en_in          (high_en),
        .timebase_en_in          (tbase_en),
        .external_clock_input_in (ext_clk),
        .timer_pin_in            (pin_level),
        .timer_output_pin_out    (pin),
        .timer_output_pin_oe_out (oe),
        .compare_a_flag_out      (af),
        .compare_p_flag_out      (pf)
    );

    always #50 ref_clk_in = ~ref_clk_in;

    // clock enables at distinct rates so each clock select gives its own period, except the two external edges, which share one
    always @(posedge ref_clk_in) begin
        cycles   <= cycles + 1;
        high_en  <= (cycles % 2 == 0);
        tbase_en <= (cycles % 3 == 0);
        if (cycles % 5 == 0) begin
            ext_clk <= !ext_clk;
        end
        if (cycles == 95000) begin
            fails++;
            end_sim();
        end
    end

    task automatic end_sim;
        $display("counts: %0d mismatches, %0d comparisons", fails, comparisons);
        if (fails == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk_v(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("BAD at %0t: value %h expected %h", $time, got, exp);
        end
    endtask : chk_v

    task automatic chk_n(input int got, input int exp);
        comparisons++;
        if (got != exp) begin
            fails++;
            $display("BAD at %0t: count %0d expected %0d", $time, got, exp);
        end
    endtask : chk_n

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        addr  <= a;
        wdata <= d;
        wr_s  <= 1'b1;
        @(posedge ref_clk_in);
        wr_s  <= 1'b0;
    endtask : wr

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge ref_clk_in);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge ref_clk_in);
        rd_s <= 1'b0;
        #1 d = rdata;
    endtask : rd

    // waits for a flag pulse under a bound, noting any compare p pulse seen
    task automatic wait_flag(input bit use_p, input int lim, output int cnt);
        cnt = 0;
        do begin
            @(posedge ref_clk_in);
            #1 cnt++;
            pseen |= (pf === 1'b1);
        end while ((use_p ? pf : af) !== 1'b1 && cnt < lim);
    endtask : wait_flag

    task automatic period(input bit use_p, input int exp, input bit p_ok);
        wait_flag(use_p, 2000, n);
        pseen = 1'b0;
        wait_flag(use_p, 2000, n);
        chk_n(n, exp);
        if (!p_ok) begin
            chk_n(pseen, 0);
        end
    endtask : period

    task automatic t_regs;
        logic [7:0] d;
        logic [7:0] exp [8] = '{8'hc0, 8'hc7, 8'h00, 8'h00, 8'hc7, 8'hc7, 8'hc7, 8'h00};
        for (int i = 0; i < 8; i++) begin
            rd(i[2:0], d);
            chk_v(d, 8'h00);
            wr(i[2:0], 8'hc7);
            rd(i[2:0], d);
            chk_v(d, exp[i]);
        end
        for (int i = 0; i < 8; i++) begin
            wr(i[2:0], 8'h00);
        end
        $display("register test done");
    endtask : t_regs

    task automatic t_count;
        logic [7:0] a;
        logic [7:0] b;
        wr(OFS_CTL_A, 8'h18);
        rd(OFS_CNT_LO, a);
        chk_v(a, 8'h01);
        repeat (20) @(posedge ref_clk_in);
        wr(OFS_CTL_A, 8'h98);
        rd(OFS_CNT_LO, a);
        repeat (10) @(posedge ref_clk_in);
        rd(OFS_CNT_LO, b);
        chk_v(b, a);
        wr(OFS_CTL_A, 8'h18);
        rd(OFS_CNT_LO, b);
        chk_v(b, a + 8'h01);
        wr(OFS_CTL_A, 8'h10);
        rd(OFS_CNT_LO, a);
        repeat (10) @(posedge ref_clk_in);
        rd(OFS_CNT_LO, b);
        chk_v(b, a);
        wr(OFS_CTL_A, 8'h18);
        rd(OFS_CNT_LO, b);
        chk_v(b, 8'h01);
        $display("count test done");
    endtask : t_count

    task automatic t_cmp;
        logic [1:0] f;
        wr(OFS_CMPA_L, 8'h10);
        for (int k = 0; k < 8; k++) begin
            f = k[1:0];
            wr(OFS_CTL_A, 8'h10);
            wr(OFS_CTL_B, {2'b00, f, 1'b1, k[2], 2'b01});
            wr(OFS_CTL_A, 8'h18);
            repeat (3) @(posedge ref_clk_in);
            #1 chk_v({6'h00, oe, pin}, {7'h01, !k[2]});
            wait_flag(1'b0, 40, n);
            repeat (3) @(posedge ref_clk_in);
            #1 chk_v({7'h00, pin}, {7'h00, (f == 2'h0 || f == 2'h2) ^ k[2]});
        end
        wr(OFS_CTL_A, 8'h10);
        wr(OFS_CTL_B, 8'hc1);
        wr(OFS_CTL_A, 8'h18);
        #1 chk_v({7'h00, oe}, 8'h00);
        period(1'b0, 16, 1'b0);
        wr(OFS_CMPP, 8'h01);
        wr(OFS_CTL_B, 8'hc0);
        period(1'b1, 256, 1'b1);
        wr(OFS_CTL_A, 8'h10);
        wr(OFS_CMPP, 8'h00);
        wr(OFS_CTL_A, 8'h18);
        wait_flag(1'b1, 70000, n);
        chk_n(n >> 4, 4096);
        $display("compare test done");
    endtask : t_cmp

    task automatic t_clk;
        int per [8] = '{16, 4, 128, 512, 12, 64, 40, 40};
        wr(OFS_CTL_B, 8'hc1);
        wr(OFS_CMPA_L, 8'h04);
        for (int s = 0; s < 8; s++) begin
            wr(OFS_CTL_A, 8'h00);
            wr(OFS_CTL_A, {1'b0, s[2:0], 4'h8});
            period(1'b0, per[s], 1'b0);
        end
        $display("clock select test done");
    endtask : t_clk

    task automatic t_pwm;
        logic [23:0] cfg [6] = '{24'ha94000, 24'hab0003, 24'h894000, 24'h994000, 24'hb94000, 24'ha14000};
        int win [6] = '{512, 768, 256, 256, 512, 512};
        int hi_exp [6] = '{128, 256, 0, 256, 64, 384};
        int hi;
        wr(OFS_CMPP, 8'h01);
        for (int r = 0; r < 6; r++) begin
            wr(OFS_CTL_A, 8'h00);
            wr(OFS_CTL_B, cfg[r][23:16]);
            wr(OFS_CMPA_L, cfg[r][15:8]);
            wr(OFS_CMPA_H, cfg[r][7:0]);
            wr(OFS_CTL_A, 8'h18);
            hi = 0;
            repeat (win[r]) begin
                @(posedge ref_clk_in);
                #1 hi += (pin === 1'b1);
            end
            chk_n((hi + 2) >> 2, hi_exp[r] >> 2);
        end
        $display("pwm test done");
    endtask : t_pwm

    task automatic t_cap;
        wr(OFS_CMPA_L, 8'h00);
        wr(OFS_CMPA_H, 8'h00);
        for (int f = 0; f < 4; f++) begin
            wr(OFS_CTL_A, 8'h00);
            wr(OFS_CTL_B, {2'b01, f[1:0], 4'h0});
            wr(OFS_CTL_A, 8'h18);
            pin_level <= 1'b1;
            wait_flag(1'b0, 8, n);
            chk_n(af === 1'b1, !f[0]);
            @(posedge ref_clk_in);
            pin_level <= 1'b0;
            wait_flag(1'b0, 8, n);
            chk_n(af === 1'b1, f[0] ^ f[1]);
        end
        $display("capture test done");
    endtask : t_cap

    initial begin
        repeat (16) @(posedge ref_clk_in);
        srst_in <= 1'b0;
        t_regs();
        t_count();
        t_cmp();
        t_clk();
        t_pwm();
        t_cap();
        end_sim();
    end
endmodule : stmrc_timer_tb
`default_nettype wire
